// ==== hprk_ctrl.sv ====
// hprk_ctrl.sv - keypad control of host power switch and reset
// assumes: ahb-lite single slave, hclk 20 MHz, keys and sense are pins
`timescale 1ns/1ps
`include "hprk_defines.svh"
module hprk_ctrl #(
    parameter int TICK_CYCLES = `HPRK_TICK_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sense_pin,
    input wire logic confirm_key_n,
    input wire logic cancel_key_n,
    input wire logic wdog_rst_req,
    output logic sense_pulldown_en,
    output logic pwr_sw_o,
    output logic pwr_sw_oe,
    output logic host_rst_o,
    output logic host_rst_oe,
    output logic display_blank,
    output logic self_restart,
    output hprk_pkg::hprk_state_t state_o
);
    import hprk_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pins_s; // sense, confirm, cancel after sync
    logic sense; // host switched supply present
    logic confirm; // confirm key pressed
    logic cancel; // cancel key pressed

    hprk_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({sense_pin, ~confirm_key_n, ~cancel_key_n}),
        .sync_out(pins_s)
    );
    assign sense = pins_s[2];
    assign confirm = pins_s[1];
    assign cancel = pins_s[0];

    // pad keeps a floating sense line low when host supply is absent
    assign sense_pulldown_en = 1'b1;

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    logic [`HPRK_CTRL_W-1:0] ctrl; // enables, polarities, blank
    logic [15:0] pulse_ms; // power pulse width in ms
    logic wr_pend; // write data phase pending
    logic [3:0] wr_addr; // captured write offset
    hprk_state_t state; // sequencer state
    logic [15:0] tmr_ms; // pulse timer
    logic rst_kbd; // reset pulse came from keypad

    wire addr_ok = hsel & hready & htrans[1];
    wire we_ctrl = wr_pend & (wr_addr == `HPRK_A_CTRL);
    wire we_pulse = wr_pend & (wr_addr == `HPRK_A_PULSE);
    wire [3:0] ra = haddr[3:0];
    wire [31:0] st_word = {4'h0, tmr_ms, pwr_sw_oe, host_rst_oe,
        state, cancel, confirm, sense, display_blank};
    wire [31:0] rd_mux =
        (ra == `HPRK_A_CTRL) ? {26'h0000000, ctrl} :
        (ra == `HPRK_A_PULSE) ? {16'h0000, pulse_ms} :
        (ra == `HPRK_A_STATUS) ? st_word : 32'h00000000;

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // address phase capture and read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 4'h0;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[3:0];
            if (addr_ok & ~hwrite) begin
                hrdata <= rd_mux; // unmapped reads as zero
            end
        end
    end

    // software-owned configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `HPRK_CTRL_RST;
            pulse_ms <= `HPRK_PULSE_DEF_MS;
        end else begin
            if (we_ctrl) begin
                ctrl <= hwdata[`HPRK_CTRL_W-1:0];
            end
            if (we_pulse) begin
                pulse_ms <= hwdata[15:0];
            end
        end
    end

    wire en_on = ctrl[`HPRK_B_EN_ON];
    wire en_off = ctrl[`HPRK_B_EN_OFF];
    wire en_rst = ctrl[`HPRK_B_EN_RST];
    wire pwr_inv = ctrl[`HPRK_B_PWR_INV];
    wire rst_inv = ctrl[`HPRK_B_RST_INV];
    wire blank_en = ctrl[`HPRK_B_BLANK];

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    // the tick restarts when a pulse starts so pulse widths are exact;
    // key holds may end up to one tick early, a harmless slack
    logic [14:0] tick_cnt; // cycles into current ms
    logic load; // timer load this cycle
    wire tick = (tick_cnt == 15'(TICK_CYCLES - 1));

    // ms prescaler, restarted on each timer load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= 15'h0000;
        end else if (tick | load) begin
            tick_cnt <= 15'h0000;
        end else begin
            tick_cnt <= tick_cnt + 15'h0001;
        end
    end

    // ----------------------------------------------------------------
    // key hold measurement
    // ----------------------------------------------------------------
    logic [2:0] cond_prev; // last cycle's hold condition
    logic [12:0] hold_ms; // ms the condition has stood
    wire c_on = ~sense & confirm & en_on;
    wire c_off = sense & cancel & en_off;
    wire c_rst = sense & confirm & en_rst;
    wire [2:0] cond = {c_on, c_off, c_rst};
    wire steady = (cond != 3'h0) & (cond == cond_prev);
    wire done_on = c_on & (hold_ms >= `HPRK_ON_HOLD_MS);
    wire done_off = c_off & (hold_ms >= `HPRK_OFF_HOLD_MS);
    wire done_rst = c_rst & (hold_ms >= `HPRK_RST_HOLD_MS);

    // count only an unbroken hold; a release or change starts over
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_prev <= 3'h0;
            hold_ms <= 13'h0000;
        end else begin
            cond_prev <= cond;
            if (!steady || state != HPRK_IDLE) begin
                hold_ms <= 13'h0000;
            end else if (tick && hold_ms != 13'h1fff) begin
                hold_ms <= hold_ms + 13'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    hprk_state_t next_state;
    logic [15:0] next_tmr;
    logic next_kbd;
    wire tmr_zero = (tmr_ms == 16'h0000);

    // next-state and timer load decisions
    always_comb begin
        next_state = state;
        next_tmr = tmr_ms;
        next_kbd = rst_kbd;
        load = 1'b0;
        unique case (state)
            HPRK_IDLE: begin
                if (wdog_rst_req) begin
                    // watchdog shares the reset output, no restart
                    next_state = HPRK_RST;
                    next_tmr = `HPRK_RST_PULSE_MS;
                    next_kbd = 1'b0;
                    load = 1'b1;
                end else if (done_on) begin
                    next_state = HPRK_PWR_ON;
                    next_tmr = pulse_ms;
                    load = 1'b1;
                end else if (done_off) begin
                    next_state = HPRK_OFF_MIN;
                    next_tmr = pulse_ms;
                    load = 1'b1;
                end else if (done_rst) begin
                    next_state = HPRK_RST;
                    next_tmr = `HPRK_RST_PULSE_MS;
                    next_kbd = 1'b1;
                    load = 1'b1;
                end
            end
            HPRK_PWR_ON: begin
                if (tmr_zero) begin
                    next_state = HPRK_IDLE;
                end
            end
            HPRK_OFF_MIN: begin
                // full minimum width regardless of the key
                if (tmr_zero && cancel) begin
                    next_state = HPRK_OFF_EXT;
                    next_tmr = `HPRK_OFF_EXT_MS;
                    load = 1'b1;
                end else if (tmr_zero) begin
                    next_state = HPRK_IDLE;
                end
            end
            HPRK_OFF_EXT: begin
                if (!cancel || tmr_zero) begin
                    next_state = HPRK_IDLE;
                end
            end
            HPRK_RST: begin
                if (tmr_zero) begin
                    next_state = rst_kbd ? HPRK_RESTART : HPRK_IDLE;
                end
            end
            HPRK_RESTART: begin
                next_state = HPRK_IDLE;
            end
            default: begin
                next_state = HPRK_IDLE; // illegal code recovers
            end
        endcase
    end

    // state, timer and source flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= HPRK_IDLE;
            tmr_ms <= 16'h0000;
            rst_kbd <= 1'b0;
        end else begin
            state <= next_state;
            rst_kbd <= next_kbd;
            if (load) begin
                tmr_ms <= next_tmr;
            end else if (tick && !tmr_zero) begin
                tmr_ms <= tmr_ms - 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    wire next_pwr_oe = (next_state == HPRK_PWR_ON) |
        (next_state == HPRK_OFF_MIN) | (next_state == HPRK_OFF_EXT);
    wire next_rst_oe = (next_state == HPRK_RST);

    // drive only while pulsing, released otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_sw_oe <= 1'b0;
            pwr_sw_o <= 1'b0;
            host_rst_oe <= 1'b0;
            host_rst_o <= 1'b0;
            display_blank <= 1'b0;
        end else begin
            pwr_sw_oe <= next_pwr_oe;
            pwr_sw_o <= pwr_inv;
            host_rst_oe <= next_rst_oe;
            host_rst_o <= rst_inv;
            // only the display is blanked; fan settings are left alone
            display_blank <= blank_en & ~sense;
        end
    end

    assign self_restart = (state == HPRK_RESTART);
    assign state_o = state;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_ext_stop;
        state == HPRK_OFF_EXT && !cancel;
    endsequence

    sequence s_kbd_rst_end;
        state == HPRK_RST && tmr_zero && rst_kbd;
    endsequence

    idle_released_a: assert property (
        state == HPRK_IDLE |-> !pwr_sw_oe && !host_rst_oe)
        else $error("output driven while idle");

    pwr_level_a: assert property (
        pwr_sw_oe |-> pwr_sw_o == $past(pwr_inv))
        else $error("power drive level wrong");

    rst_level_a: assert property (
        host_rst_oe |-> host_rst_o == $past(rst_inv))
        else $error("reset drive level wrong");

    power_on_a: assert property (
        state == HPRK_IDLE && !wdog_rst_req && done_on
        |=> state == HPRK_PWR_ON && pwr_sw_oe
        && tmr_ms == $past(pulse_ms))
        else $error("power-on pulse not started");

    off_min_a: assert property (
        state == HPRK_OFF_MIN && tmr_ms > 16'h0001 |=> pwr_sw_oe [*2])
        else $error("hard-off pulse cut short");

    ext_stop_a: assert property (
        s_ext_stop |=> state == HPRK_IDLE ##1 !pwr_sw_oe)
        else $error("hard-off not ended on release");

    restart_a: assert property (
        s_kbd_rst_end |=> self_restart ##1 !self_restart)
        else $error("no restart after keypad reset");

    blank_a: assert property (
        blank_en && !sense |=> display_blank)
        else $error("display not blanked");

    hold_cancel_a: assert property (
        state == HPRK_IDLE && cond == 3'h0 |=> hold_ms == 13'h0000)
        else $error("hold count survived release");

endmodule

// ==== hprk_defines.svh ====
// hprk_defines.svh - constants of the host power/reset keypad control
// assumes: included by its bare name from the control module only
`ifndef HPRK_DEFINES_SVH
`define HPRK_DEFINES_SVH

// ----------------------------------------------------------------
// timebase
// ----------------------------------------------------------------
`define HPRK_CLK_NS 50
`define HPRK_TICK_NS 1000000
`define HPRK_TICK_CYC (`HPRK_TICK_NS / `HPRK_CLK_NS)

// ----------------------------------------------------------------
// key hold and pulse times, in milliseconds
// ----------------------------------------------------------------
`define HPRK_ON_HOLD_MS 13'h0fa
`define HPRK_OFF_HOLD_MS 13'hfa0
`define HPRK_RST_HOLD_MS 13'hfa0
`define HPRK_OFF_EXT_MS 16'h1388
`define HPRK_RST_PULSE_MS 16'h03e8
`define HPRK_PULSE_DEF_MS 16'h03e8

// ----------------------------------------------------------------
// register byte offsets (haddr[3:0])
// ----------------------------------------------------------------
`define HPRK_A_CTRL 4'h0
`define HPRK_A_PULSE 4'h4
`define HPRK_A_STATUS 4'h8

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define HPRK_B_EN_ON 0
`define HPRK_B_EN_OFF 1
`define HPRK_B_EN_RST 2
`define HPRK_B_PWR_INV 3
`define HPRK_B_RST_INV 4
`define HPRK_B_BLANK 5
`define HPRK_CTRL_W 6
`define HPRK_CTRL_RST 6'h00

`endif

// ==== hprk_mobo.sv ====
// hprk_mobo.sv - motherboard power and reset switch inputs
// assumes: device enables resolve the pins; board pull-ups hold them high
`timescale 1ns/1ps
module hprk_mobo (
    input wire logic hclk,
    input wire logic pwr_sw_o,
    input wire logic pwr_sw_oe,
    input wire logic host_rst_o,
    input wire logic host_rst_oe,
    output logic sense_pin,
    output int n_pwr,
    output int pwr_w,
    output logic pwr_lvl,
    output int rst_w,
    output logic rst_lvl
);
    // ----
    // pin levels
    // ----
    logic pwr_pin; // released pin floats to board pull-up
    logic rst_pin; // same for the reset switch input
    logic host_on; // switched supply state
    logic pwr_d; // enable one cycle late, for edge finding
    logic rst_d;
    int pc; // cycles the power pin has been driven
    int rc; // cycles the reset pin has been driven
    assign pwr_pin = pwr_sw_oe ? pwr_sw_o : 1'h1;
    assign rst_pin = host_rst_oe ? host_rst_o : 1'h1;
    // host off reads low through the device pull-down
    assign sense_pin = host_on;
    initial begin
        host_on = 1'h0;
        {pwr_d, rst_d, pwr_lvl, rst_lvl} = 4'h0;
        {pc, rc, n_pwr, pwr_w, rst_w} = '0;
    end
    // ----
    // pulse measurement; any finished power pulse toggles the host
    // ----
    // control pins are never given to user gpio, so default drive holds
    always @(posedge hclk) begin
        pwr_d <= pwr_sw_oe;
        rst_d <= host_rst_oe;
        if (pwr_sw_oe) begin
            pc <= pc + 1;
            pwr_lvl <= pwr_pin;
        end else if (pwr_d) begin
            pwr_w <= pc;
            n_pwr <= n_pwr + 1;
            pc <= 0;
            host_on <= !host_on;
        end
        if (host_rst_oe) begin
            rc <= rc + 1;
            rst_lvl <= rst_pin;
        end else if (rst_d) begin
            rst_w <= rc;
            rc <= 0;
        end
    end
endmodule

// ==== hprk_pkg.sv ====
// hprk_pkg.sv - types of the host power/reset keypad control
// assumes: nothing beyond the defines header
package hprk_pkg;

    // ----------------------------------------------------------------
    // sequencer states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        HPRK_IDLE = 6'h01, // outputs released
        HPRK_PWR_ON = 6'h02, // power-on pulse
        HPRK_OFF_MIN = 6'h04, // hard-off minimum pulse
        HPRK_OFF_EXT = 6'h08, // hard-off stretched by key
        HPRK_RST = 6'h10, // host reset pulse
        HPRK_RESTART = 6'h20 // one-cycle self restart
    } hprk_state_t;

endpackage

// ==== hprk_sync.sv ====
// hprk_sync.sv - three-flop synchroniser with agreement filter
// assumes: inputs are asynchronous pins, one clock hclk
`timescale 1ns/1ps
module hprk_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);

    // ----------------------------------------------------------------
    // per-bit chain
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_bit
            logic s1; // metastable stage, read by s2 only
            logic s2;
            logic s3;
            // shift chain; output follows once s2 and s3 agree
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    s1 <= async_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        sync_out[i] <= s3;
                    end
                end
            end
        end
    endgenerate

endmodule

// ==== tb.sv ====
// tb.sv - self-checking bench of the keypad power/reset control
// assumes: hprk_ctrl with a shortened tick, motherboard model beside it
`timescale 1ns/1ps
module tb;
    import hprk_pkg::*;
    localparam int T = 2; // cycles per ms tick, shortened for the run
    localparam int P = 20; // pulse width in ms written to the block
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2; // whole words only
    logic confirm_key_n = 1'h1;
    logic cancel_key_n = 1'h1;
    logic wdog_rst_req = 1'h0;
    logic hready, hresp, sense_pin, pd_en, pwr_sw_o, pwr_sw_oe;
    logic host_rst_o, host_rst_oe, display_blank, self_restart;
    logic pwr_lvl, rst_lvl;
    logic [31:0] hrdata;
    logic [1:0] oes; // both output enables, indexed
    hprk_state_t state_o;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n_restart = 0;
    int r;
    int n_pwr, pwr_w, rst_w;
    assign oes = {host_rst_oe, pwr_sw_oe};
    hprk_ctrl #(.TICK_CYCLES(T)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .sense_pin(sense_pin), .confirm_key_n(confirm_key_n),
        .cancel_key_n(cancel_key_n), .wdog_rst_req(wdog_rst_req),
        .sense_pulldown_en(pd_en), .pwr_sw_o(pwr_sw_o),
        .pwr_sw_oe(pwr_sw_oe), .host_rst_o(host_rst_o),
        .host_rst_oe(host_rst_oe), .display_blank(display_blank),
        .self_restart(self_restart), .state_o(state_o));
    hprk_mobo mobo (.hclk(hclk), .pwr_sw_o(pwr_sw_o),
        .pwr_sw_oe(pwr_sw_oe), .host_rst_o(host_rst_o),
        .host_rst_oe(host_rst_oe), .sense_pin(sense_pin),
        .n_pwr(n_pwr), .pwr_w(pwr_w), .pwr_lvl(pwr_lvl),
        .rst_w(rst_w), .rst_lvl(rst_lvl));
    // ----
    // clock, restart counter, hang limit
    // ----
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        if (self_restart === 1'h1) begin
            n_restart <= n_restart + 1;
        end
    end
    // ceiling sits above the roughly 50k cycles the sequence needs
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 65000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ----
    // tasks
    // ----
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // tolerance of one tick early, two late, for tick phase and sync
    function automatic logic [31:0] inr(input int v, input int ms);
        return {31'h0, (v >= ms * T - T) && (v <= ms * T + 2 * T)};
    endfunction
    // single ahb transfer; read data taken at the data phase's end
    task automatic bus(input logic wr, input logic [31:0] a,
            input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic keys(input logic c, input logic x);
        confirm_key_n <= c;
        cancel_key_n <= x;
    endtask
    // bounded wait for an enable to reach a level
    task automatic wait_oe(input int i, input logic v, input int lim);
        int k;
        k = 0;
        while (oes[i] !== v && k < lim) begin
            @(posedge hclk);
            k++;
        end
        check("oe level", {31'h0, oes[i]}, {31'h0, v});
    endtask
    // hold a key until a pulse ends; early lets go at its start
    task automatic pulse_by(input int key, input int oe, input logic early);
        keys(key != 0, key == 0);
        wait_oe(oe, 1'h1, 4010 * T + 40);
        if (early) begin
            keys(1'h1, 1'h1);
        end
        wait_oe(oe, 1'h0, 5100 * T);
        keys(1'h1, 1'h1);
        repeat (8) @(posedge hclk);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, 32'h0, 32'h0);
        check("ctrl reset", rd, 32'h0);
        bus(1'h0, 32'h4, 32'h0);
        check("pulse reset", rd, 32'h3e8);
        bus(1'h0, 32'hc, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("pwr oe idle", pwr_sw_oe, 32'h0);
        check("rst oe idle", host_rst_oe, 32'h0);
        check("sense pulldown", pd_en, 32'h1);
        // functions off: a long hold does nothing
        keys(1'h0, 1'h1);
        repeat (300 * T) @(posedge hclk);
        keys(1'h1, 1'h1);
        repeat (20) @(posedge hclk);
        check("disabled on", n_pwr, 32'h0);
        bus(1'h1, 32'h4, P);
        bus(1'h1, 32'h0, 32'h2f);
        bus(1'h0, 32'h0, 32'h0);
        check("ctrl rw", rd, 32'h2f);
        repeat (8) @(posedge hclk);
        check("blank off", display_blank, 32'h1);
        // status: blank set, idle state, timer clear, keys up
        bus(1'h0, 32'h8, 32'h0);
        check("status", rd, 32'h11);
        check("okay resp", hresp, 32'h0);
        check("state idle", state_o, HPRK_IDLE);
        // let go short of the hold time
        keys(1'h0, 1'h1);
        repeat (200 * T) @(posedge hclk);
        keys(1'h1, 1'h1);
        repeat (20) @(posedge hclk);
        check("early release", n_pwr, 32'h0);
        pulse_by(0, 0, 1'h1);
        check("on width", inr(pwr_w, P), 32'h1);
        check("on level", pwr_lvl, 32'h1);
        check("blank on", display_blank, 32'h0);
        pulse_by(1, 0, 1'h0);
        check("off held", inr(pwr_w, P + 5000), 32'h1);
        pulse_by(0, 0, 1'h1);
        pulse_by(1, 0, 1'h1);
        check("off min", inr(pwr_w, P), 32'h1);
        check("off count", n_pwr, 32'h4);
        pulse_by(0, 0, 1'h1);
        // cancel let go part way into the stretch; six cycles of key
        // path through the synchroniser are taken off the hold
        keys(1'h1, 1'h0);
        wait_oe(0, 1'h1, 4010 * T + 40);
        repeat ((P + 100) * T - 6) @(posedge hclk);
        keys(1'h1, 1'h1);
        wait_oe(0, 1'h0, 40);
        repeat (8) @(posedge hclk);
        check("off release", inr(pwr_w, P + 100), 32'h1);
        check("off release count", n_pwr, 32'h6);
        pulse_by(0, 0, 1'h1);
        r = n_restart;
        pulse_by(0, 1, 1'h1);
        check("rst width", inr(rst_w, 1000), 32'h1);
        check("rst level", rst_lvl, 32'h0);
        check("restart", n_restart, r + 1);
        // watchdog shares the reset pin but no self restart
        wdog_rst_req <= 1'h1;
        @(posedge hclk);
        wdog_rst_req <= 1'h0;
        wait_oe(1, 1'h1, 20);
        wait_oe(1, 1'h0, 1100 * T);
        repeat (8) @(posedge hclk);
        check("wdog width", inr(rst_w, 1000), 32'h1);
        check("wdog restart", n_restart, r + 1);
        print_verdict();
    end
endmodule
